// ---- pkg/addr_decode_pkg.sv ----
// Constants, types and register map of the system address decoder.
package addr_decode_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] KBC_IN_OFFSET = 4'h8;
  localparam logic [3:0] KBC_TST_OFFSET = 4'hc;

  // Control register fields.
  localparam int CTRL_HISPEED_BIT   = 0;
  localparam int CTRL_EXP_RAM_BIT   = 1;
  localparam int CTRL_SPK_GATE_BIT  = 2;
  localparam int CTRL_SPK_DATA_BIT  = 3;

  // Keyboard controller input port fields.
  localparam int KBC_SPEED_BIT   = 5;
  localparam int KBC_DISPLAY_BIT = 6;
  localparam int KBC_LOCK_BIT    = 7;

  // ----------------------------------------------------------------
  // Memory map boundaries (24-bit)
  // ----------------------------------------------------------------
  localparam logic [23:0] MEM_RAM_LO_END  = 24'h07ffff;
  localparam logic [23:0] MEM_RAM_HI_BASE = 24'h080000;
  localparam logic [23:0] MEM_RAM_HI_END  = 24'h09ffff;
  localparam logic [23:0] MEM_VID_BASE    = 24'h0a0000;
  localparam logic [23:0] MEM_VID_END     = 24'h0bffff;
  localparam logic [23:0] MEM_OPT_BASE    = 24'h0c0000;
  localparam logic [23:0] MEM_OPT_END     = 24'h0dffff;
  localparam logic [7:0]  MEM_ROM_E_SEG   = 8'h0e;
  localparam logic [7:0]  MEM_ROM_F_SEG   = 8'h0f;
  localparam logic [7:0]  MEM_ROM_E_ALIAS = 8'hfe;
  localparam logic [7:0]  MEM_ROM_F_ALIAS = 8'hff;

  // ----------------------------------------------------------------
  // I/O map (10-bit)
  // ----------------------------------------------------------------
  localparam logic [9:0] IO_DMA1_BASE  = 10'h000;
  localparam logic [9:0] IO_DMA1_END   = 10'h01f;
  localparam logic [9:0] IO_PIC1_BASE  = 10'h020;
  localparam logic [9:0] IO_PIC1_END   = 10'h03f;
  localparam logic [9:0] IO_RTC_BASE   = 10'h040;
  localparam logic [9:0] IO_RTC_END    = 10'h05f;
  localparam logic [9:0] IO_KBC_BASE   = 10'h060;
  localparam logic [9:0] IO_KBC_END    = 10'h06f;
  localparam logic [9:0] IO_RTCM_BASE  = 10'h070;
  localparam logic [9:0] IO_RTCM_END   = 10'h07f;
  localparam logic [9:0] IO_PAGE_BASE  = 10'h080;
  localparam logic [9:0] IO_PAGE_END   = 10'h09f;
  localparam logic [9:0] IO_PIC2_BASE  = 10'h0a0;
  localparam logic [9:0] IO_PIC2_END   = 10'h0bf;
  localparam logic [9:0] IO_DMA2_BASE  = 10'h0c0;
  localparam logic [9:0] IO_DMA2_END   = 10'h0df;
  localparam logic [9:0] IO_RSVD_BASE  = 10'h0e0;
  localparam logic [9:0] IO_RSVD_END   = 10'h0ef;
  localparam logic [9:0] IO_FPU_CLRBSY = 10'h0f0;
  localparam logic [9:0] IO_FPU_RESET  = 10'h0f1;
  localparam logic [9:0] IO_FPU_BASE   = 10'h0f8;
  localparam logic [9:0] IO_FPU_END    = 10'h0ff;

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 250000;
  localparam int LOW_SPEED_KHZ = 6000;
  // Half period of the low-speed enable toggle, in core cycles.
  localparam int LOW_HALF_CYC = CORE_CLK_KHZ / (2 * LOW_SPEED_KHZ);
  localparam logic [7:0] LOW_HALF_CNT = 8'(LOW_HALF_CYC);

  // Reset values.
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Decoder target selection.
  typedef enum logic [3:0] {
    TGT_NONE     = 4'h0,
    TGT_RAM      = 4'h1,
    TGT_ROM      = 4'h2,
    TGT_EXP_MEM  = 4'h3,
    TGT_DMA1     = 4'h4,
    TGT_PIC1     = 4'h5,
    TGT_RTC      = 4'h6,
    TGT_KBC      = 4'h7,
    TGT_PAGE     = 4'h8,
    TGT_PIC2     = 4'h9,
    TGT_DMA2     = 4'ha,
    TGT_FPU      = 4'hb,
    TGT_EXP_IO   = 4'hc,
    TGT_EXP_RAM  = 4'hd
  } target_t;

endpackage

// ---- design/system_address_decoder.sv ----
// System address decoder with speed, speaker and keyboard-strap glue.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
module system_address_decoder (
  // Clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         srst_in,
  // Processor cycle
  input  wire logic [23:0]                  cpu_addr_in,
  input  wire logic                         mem_cycle_in,
  input  wire logic                         io_cycle_in,
  // Memory selects
  output logic                              ram_sel_out,
  output logic                              exp_ram_sel_out,
  output logic                              rom_sel_out,
  output logic                              exp_mem_sel_out,
  // I/O selects
  output logic                              dma1_sel_out,
  output logic                              pic1_sel_out,
  output logic                              rtc_sel_out,
  output logic                              kbc_sel_out,
  output logic                              page_sel_out,
  output logic                              pic2_sel_out,
  output logic                              dma2_sel_out,
  output logic                              fpu_sel_out,
  output logic                              exp_io_sel_out,
  output logic                              fpu_clr_busy_out,
  output logic                              fpu_reset_out,
  output addr_decode_pkg::target_t          target_out,
  // Speed, speaker and strap pins
  input  wire logic                         osc_clk_in,
  input  wire logic                         timer2_out_in,
  input  wire logic                         kbd_lock_in,
  input  wire logic                         default_speed_strap_in,
  input  wire logic                         display_type_switch_in,
  input  wire logic                         kbd_clk_in,
  input  wire logic                         kbd_data_in,
  output logic                              cpu_clk_out,
  output logic                              speaker_out,
  output logic                              speed_led_hi_out,
  output logic [7:0]                        kbc_in_port_out,
  output logic                              kbc_test0_out,
  output logic                              kbc_test1_out,
  // Avalon-MM register slave
  input  wire logic [3:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic [31:0]                       avs_readdata,
  output logic                              avs_waitrequest
);
  import addr_decode_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  ctrl;
    logic        strap_valid;
    logic [2:0]  sync_osc;
    logic [2:0]  sync_t2;
    logic [2:0]  sync_lock;
    logic [2:0]  sync_spd;
    logic [2:0]  sync_disp;
    logic [2:0]  sync_kclk;
    logic [2:0]  sync_kdat;
    logic        osc;
    logic        t2;
    logic        lock;
    logic        spd;
    logic        disp;
    logic        kclk;
    logic        kdat;
    logic [7:0]  div_cnt;
    logic        low_clk;
    logic        ack;
    logic [31:0] rdata;
    target_t     target;
    logic        clr_busy;
    logic        fpu_rst;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic in_io(input logic [9:0] a, input logic [9:0] lo,
                                 input logic [9:0] hi);
    in_io = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_mem(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_mem = (a >= lo) && (a <= hi);
  endfunction

  // A pin input counts as changed once the second and third stages agree.
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  function automatic target_t mem_decode(input logic [23:0] a, input logic exp_ram);
    logic [7:0] seg;
    seg = a[23:16];
    if (a <= MEM_RAM_LO_END) begin
      mem_decode = TGT_RAM;
    end else if (in_mem(a, MEM_RAM_HI_BASE, MEM_RAM_HI_END)) begin
      mem_decode = exp_ram ? TGT_EXP_RAM : TGT_RAM;
    end else if (in_mem(a, MEM_VID_BASE, MEM_VID_END)) begin
      mem_decode = TGT_EXP_MEM;
    end else if (in_mem(a, MEM_OPT_BASE, MEM_OPT_END)) begin
      mem_decode = TGT_EXP_MEM;
    end else if (seg == MEM_ROM_E_SEG || seg == MEM_ROM_E_ALIAS) begin
      mem_decode = TGT_ROM;
    end else if (seg == MEM_ROM_F_SEG || seg == MEM_ROM_F_ALIAS) begin
      mem_decode = TGT_ROM;
    end else begin
      mem_decode = TGT_EXP_MEM;
    end
  endfunction

  function automatic target_t io_decode(input logic [9:0] a);
    if (in_io(a, IO_DMA1_BASE, IO_DMA1_END)) begin
      io_decode = TGT_DMA1;
    end else if (in_io(a, IO_PIC1_BASE, IO_PIC1_END)) begin
      io_decode = TGT_PIC1;
    end else if (in_io(a, IO_RTC_BASE, IO_RTC_END) || in_io(a, IO_RTCM_BASE, IO_RTCM_END)) begin
      io_decode = TGT_RTC;
    end else if (in_io(a, IO_KBC_BASE, IO_KBC_END)) begin
      io_decode = TGT_KBC;
    end else if (in_io(a, IO_PAGE_BASE, IO_PAGE_END)) begin
      io_decode = TGT_PAGE;
    end else if (in_io(a, IO_PIC2_BASE, IO_PIC2_END)) begin
      io_decode = TGT_PIC2;
    end else if (in_io(a, IO_DMA2_BASE, IO_DMA2_END)) begin
      io_decode = TGT_DMA2;
    end else if (in_io(a, IO_RSVD_BASE, IO_RSVD_END)) begin
      io_decode = TGT_NONE;
    end else if (a == IO_FPU_CLRBSY || a == IO_FPU_RESET ||
                 in_io(a, IO_FPU_BASE, IO_FPU_END)) begin
      io_decode = TGT_FPU;
    end else begin
      io_decode = TGT_EXP_IO;
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] io_a;
    logic       hit;
    io_a    = cpu_addr_in[9:0];
    hit     = 1'b0;
    state_d = state_q;

    state_d.sync_osc  = {state_q.sync_osc[1:0], osc_clk_in};
    state_d.sync_t2   = {state_q.sync_t2[1:0], timer2_out_in};
    state_d.sync_lock = {state_q.sync_lock[1:0], kbd_lock_in};
    state_d.sync_spd  = {state_q.sync_spd[1:0], default_speed_strap_in};
    state_d.sync_disp = {state_q.sync_disp[1:0], display_type_switch_in};
    state_d.sync_kclk = {state_q.sync_kclk[1:0], kbd_clk_in};
    state_d.sync_kdat = {state_q.sync_kdat[1:0], kbd_data_in};
    state_d.osc  = filt(state_q.sync_osc, state_q.osc);
    state_d.t2   = filt(state_q.sync_t2, state_q.t2);
    state_d.lock = filt(state_q.sync_lock, state_q.lock);
    state_d.spd  = filt(state_q.sync_spd, state_q.spd);
    state_d.disp = filt(state_q.sync_disp, state_q.disp);
    state_d.kclk = filt(state_q.sync_kclk, state_q.kclk);
    state_d.kdat = filt(state_q.sync_kdat, state_q.kdat);

    // The strap sets the power-on speed once the filter has settled.
    if (!state_q.strap_valid && state_q.sync_spd[1] == state_q.sync_spd[2]) begin
      state_d.strap_valid = 1'b1;
      state_d.ctrl[CTRL_HISPEED_BIT] = ~state_q.sync_spd[2];
    end

    // Fixed low rate is divided from the core clock.
    if (state_q.div_cnt >= LOW_HALF_CNT - 8'h01) begin
      state_d.div_cnt = 8'h00;
      state_d.low_clk = ~state_q.low_clk;
    end else begin
      state_d.div_cnt = state_q.div_cnt + 8'h01;
    end

    // Decode is registered: selects follow the address by one cycle.
    if (mem_cycle_in) begin
      state_d.target = mem_decode(cpu_addr_in, state_q.ctrl[CTRL_EXP_RAM_BIT]);
    end else if (io_cycle_in) begin
      state_d.target = io_decode(io_a);
    end else begin
      state_d.target = TGT_NONE;
    end
    state_d.clr_busy = io_cycle_in && !mem_cycle_in && io_a == IO_FPU_CLRBSY;
    state_d.fpu_rst  = io_cycle_in && !mem_cycle_in && io_a == IO_FPU_RESET;

    // Avalon slave: one wait cycle, answer at the second edge.
    state_d.ack = (avs_read || avs_write) && !state_q.ack;
    // A write lands only on the edge that completes the transfer.
    if (avs_write && state_q.ack && avs_address == CTRL_OFFSET) begin
      state_d.ctrl = avs_writedata[3:0];
    end
    if (avs_read && !state_q.ack) begin
      unique case (avs_address)
        CTRL_OFFSET:    begin
          state_d.rdata = {28'h0000000, state_q.ctrl};
          hit = 1'b1;
        end
        STATUS_OFFSET:  begin
          state_d.rdata = {24'h000000, 4'(state_q.target), state_q.low_clk,
                           state_q.t2, state_q.ctrl[CTRL_HISPEED_BIT], state_q.strap_valid};
          hit = 1'b1;
        end
        KBC_IN_OFFSET:  begin
          state_d.rdata = {24'h000000, state_q.lock, state_q.disp, state_q.spd, 5'h10};
          hit = 1'b1;
        end
        KBC_TST_OFFSET: begin
          state_d.rdata = {30'h00000000, state_q.kdat, state_q.kclk};
          hit = 1'b1;
        end
        default:        begin
          state_d.rdata = 32'h00000000;
        end
      endcase
      if (!hit) begin
        state_d.rdata = 32'h00000000;
      end
    end

    if (srst_in) begin
      state_d.ctrl        = CTRL_RESET;
      state_d.strap_valid = 1'b0;
      state_d.div_cnt     = 8'h00;
      state_d.low_clk     = 1'b0;
      state_d.ack         = 1'b0;
      state_d.rdata       = 32'h00000000;
      state_d.target      = TGT_NONE;
      state_d.clr_busy    = 1'b0;
      state_d.fpu_rst     = 1'b0;
      state_d.osc         = 1'b0;
      state_d.t2          = 1'b0;
      state_d.lock        = 1'b0;
      state_d.spd         = 1'b0;
      state_d.disp        = 1'b0;
      state_d.kclk        = 1'b0;
      state_d.kdat        = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign target_out       = state_q.target;
  assign ram_sel_out      = state_q.target == TGT_RAM;
  assign exp_ram_sel_out  = state_q.target == TGT_EXP_RAM;
  assign rom_sel_out      = state_q.target == TGT_ROM;
  assign exp_mem_sel_out  = state_q.target == TGT_EXP_MEM;
  assign dma1_sel_out     = state_q.target == TGT_DMA1;
  assign pic1_sel_out     = state_q.target == TGT_PIC1;
  assign rtc_sel_out      = state_q.target == TGT_RTC;
  assign kbc_sel_out      = state_q.target == TGT_KBC;
  assign page_sel_out     = state_q.target == TGT_PAGE;
  assign pic2_sel_out     = state_q.target == TGT_PIC2;
  assign dma2_sel_out     = state_q.target == TGT_DMA2;
  assign fpu_sel_out      = state_q.target == TGT_FPU;
  assign exp_io_sel_out   = state_q.target == TGT_EXP_IO;
  assign fpu_clr_busy_out = state_q.clr_busy;
  assign fpu_reset_out    = state_q.fpu_rst;

  // Clock mux is glitch-prone on a live switch; software should switch at a quiet time.
  assign cpu_clk_out      = state_q.ctrl[CTRL_HISPEED_BIT] ? state_q.osc
                                                           : state_q.low_clk;
  assign speed_led_hi_out = state_q.ctrl[CTRL_HISPEED_BIT];
  assign speaker_out      = state_q.t2 & state_q.ctrl[CTRL_SPK_GATE_BIT]
                            & state_q.ctrl[CTRL_SPK_DATA_BIT];
  assign kbc_in_port_out  = {state_q.lock, state_q.disp, state_q.spd,
                             5'h10};
  assign kbc_test0_out    = state_q.kclk;
  assign kbc_test1_out    = state_q.kdat;

  assign avs_readdata     = state_q.rdata;
  assign avs_waitrequest  = (avs_read || avs_write) && !state_q.ack;

endmodule

// ---- test/system_address_decoder_props.sv ----
// Port assertions for the system address decoder.
module system_address_decoder_props (
  input wire logic        core_clk_in,
  input wire logic        srst_in,
  input wire logic [23:0] cpu_addr_in,
  input wire logic        mem_cycle_in,
  input wire logic        io_cycle_in,
  input wire logic        ram_sel_out,
  input wire logic        exp_ram_sel_out,
  input wire logic        rom_sel_out,
  input wire logic        exp_mem_sel_out,
  input wire logic        dma1_sel_out,
  input wire logic        pic1_sel_out,
  input wire logic        pic2_sel_out,
  input wire logic        exp_io_sel_out,
  input wire logic        fpu_clr_busy_out,
  input wire logic        fpu_reset_out,
  input wire logic        kbd_lock_in,
  input wire logic        kbd_clk_in,
  input wire logic        kbd_data_in,
  input wire logic [7:0]  kbc_in_port_out,
  input wire logic        kbc_test0_out,
  input wire logic        kbc_test1_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  logic       iom;
  logic [9:0] ia;
  logic [23:0] a;
  assign iom = io_cycle_in && !mem_cycle_in;
  assign ia = cpu_addr_in[9:0];
  assign a = cpu_addr_in;
  // ------------------------------------------------------------
  // Strap pins pass a three-stage filter, so allow them to settle.
  // ------------------------------------------------------------
  sequence s_pins_quiet;
    ($stable(kbd_lock_in) && $stable(kbd_clk_in) && $stable(kbd_data_in))[*8];
  endsequence
  a_ram_low: assert property (mem_cycle_in && a <= 24'h07ffff |=> ram_sel_out)
    else $error("low ram not selected");
  a_rom_alias: assert property (mem_cycle_in && (a[23:17] == 7'h07 || a[23:17] == 7'h7f)
    |=> rom_sel_out && !exp_mem_sel_out)
    else $error("rom alias not selected");
  a_opt_space: assert property (mem_cycle_in && a >= 24'h0c0000 && a <= 24'h0dffff
    |=> !ram_sel_out && !exp_ram_sel_out && !rom_sel_out)
    else $error("board memory answered in option space");
  a_exp_mem: assert property (mem_cycle_in && a >= 24'h100000 && a <= 24'hfdffff
    |=> exp_mem_sel_out)
    else $error("expansion memory not selected");
  a_dma1_sel: assert property (iom && ia <= 10'h01f |=> dma1_sel_out)
    else $error("first dma not selected");
  a_pic_pair: assert property (iom && (ia[9:5] == 5'h01 || ia[9:5] == 5'h05)
    |=> pic1_sel_out != pic2_sel_out && pic2_sel_out == $past(ia[7]))
    else $error("interrupt controller select wrong");
  a_fpu_clear: assert property (iom && ia == 10'h0f0 |=> fpu_clr_busy_out)
    else $error("coprocessor busy clear missing");
  a_fpu_cause: assert property (fpu_clr_busy_out || fpu_reset_out |-> $past(iom)
    && $past(ia[9:1]) == 9'h078 && fpu_reset_out == $past(ia[0]))
    else $error("coprocessor strobe without its address");
  a_one_select: assert property ($onehot0({ram_sel_out, exp_ram_sel_out, rom_sel_out,
    exp_mem_sel_out, dma1_sel_out, pic1_sel_out, pic2_sel_out, exp_io_sel_out}))
    else $error("several selects high");
  a_lock_bit: assert property (s_pins_quiet |-> kbc_in_port_out[7] == kbd_lock_in
    && kbc_in_port_out[4])
    else $error("lock bit wrong");
  a_test_pins: assert property (s_pins_quiet |-> kbc_test0_out == kbd_clk_in
    && kbc_test1_out == kbd_data_in)
    else $error("test inputs wrong");
endmodule
bind system_address_decoder system_address_decoder_props u_props (.core_clk_in, .srst_in,
  .cpu_addr_in, .mem_cycle_in, .io_cycle_in, .ram_sel_out, .exp_ram_sel_out, .rom_sel_out,
  .exp_mem_sel_out, .dma1_sel_out, .pic1_sel_out, .pic2_sel_out, .exp_io_sel_out,
  .fpu_clr_busy_out, .fpu_reset_out, .kbd_lock_in, .kbd_clk_in, .kbd_data_in,
  .kbc_in_port_out, .kbc_test0_out, .kbc_test1_out);

// ---- test/cpu_bus_model.sv ----
// Processor bus master model presenting memory and I/O cycles.
module cpu_bus_model (
  input  wire logic        clk_in,
  output logic [23:0]      addr_out,
  output logic             mem_out,
  output logic             io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 24'h000000;
    mem_out = 1'b0;
    io_out = 1'b0;
  end
  // Once a cycle ends the address lines float, so they show the inverse
  // of the last value instead of a stale copy.
  task automatic run(input logic mem, input logic [23:0] a, input int hold);
    @(posedge clk_in);
    addr_out <= a;
    mem_out <= mem;
    io_out <= !mem;
    repeat (hold) @(posedge clk_in);
    addr_out <= ~a;
    mem_out <= 1'b0;
    io_out <= 1'b0;
  endtask
endmodule

// ---- test/system_address_decoder_tb.sv ----
// Self-checking testbench of the system address decoder.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module system_address_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import addr_decode_pkg::*;
  logic core_clk_in, srst_in, osc_clk_in, timer2_out_in, kbd_lock_in, kbd_clk_in, kbd_data_in;
  logic default_speed_strap_in, display_type_switch_in, mem_cycle_in, io_cycle_in, osc_en;
  logic ram_sel_out, exp_ram_sel_out, rom_sel_out, exp_mem_sel_out, dma1_sel_out, pic1_sel_out;
  logic rtc_sel_out, kbc_sel_out, page_sel_out, pic2_sel_out, dma2_sel_out, fpu_sel_out;
  logic exp_io_sel_out, fpu_clr_busy_out, fpu_reset_out, cpu_clk_out, speaker_out;
  logic speed_led_hi_out, kbc_test0_out, kbc_test1_out, avs_read, avs_write, avs_waitrequest;
  logic [23:0] cpu_addr_in;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  kbc_in_port_out;
  logic [12:0] sel_v;
  target_t     target_out;
  int          error_cnt, n_compared, cyc;
  assign sel_v = {ram_sel_out, exp_ram_sel_out, rom_sel_out, exp_mem_sel_out, dma1_sel_out,
    pic1_sel_out, rtc_sel_out, kbc_sel_out, page_sel_out, pic2_sel_out, dma2_sel_out,
    fpu_sel_out, exp_io_sel_out};
  system_address_decoder dut (.core_clk_in, .srst_in, .cpu_addr_in, .mem_cycle_in,
    .io_cycle_in, .ram_sel_out, .exp_ram_sel_out, .rom_sel_out, .exp_mem_sel_out,
    .dma1_sel_out, .pic1_sel_out, .rtc_sel_out, .kbc_sel_out, .page_sel_out, .pic2_sel_out,
    .dma2_sel_out, .fpu_sel_out, .exp_io_sel_out, .fpu_clr_busy_out, .fpu_reset_out,
    .target_out, .osc_clk_in, .timer2_out_in, .kbd_lock_in, .default_speed_strap_in,
    .display_type_switch_in, .kbd_clk_in, .kbd_data_in, .cpu_clk_out, .speaker_out,
    .speed_led_hi_out, .kbc_in_port_out, .kbc_test0_out, .kbc_test1_out, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  cpu_bus_model cpu (.clk_in(core_clk_in), .addr_out(cpu_addr_in), .mem_out(mem_cycle_in),
    .io_out(io_cycle_in));
  // ------------------------------------------------------------
  // Clock, oscillator pin and hang guard
  // ------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (osc_en && cyc % 7 == 0) osc_clk_in <= !osc_clk_in;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // The request stands until an edge samples waitrequest low; only the hang guard ends a wait.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk_in); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic [12:0] exp_sel(input logic m, input logic [23:0] a, input logic xr);
    logic [9:0] i;
    int k;
    i = a[9:0];
    k = -1;
    if (m) begin
      if (a <= 24'h07ffff) k = 0;
      else if (a <= 24'h09ffff) k = xr ? 1 : 0;
      else if (a[23:17] == 7'h07 || a[23:17] == 7'h7f) k = 2;
      else k = 3;
    end else if (i >= 10'h100) k = 12;
    else if (i <= 10'h01f) k = 4;
    else if (i <= 10'h03f) k = 5;
    else if (i <= 10'h05f || (i >= 10'h070 && i <= 10'h07f)) k = 6;
    else if (i <= 10'h06f) k = 7;
    else if (i <= 10'h09f) k = 8;
    else if (i <= 10'h0bf) k = 9;
    else if (i <= 10'h0df) k = 10;
    else if (i == 10'h0f0 || i == 10'h0f1 || i >= 10'h0f8) k = 11;
    else if (i >= 10'h0f2) k = 12;
    return (k < 0) ? 13'h0 : 13'h1000 >> k;
  endfunction
  function automatic target_t exp_tgt(input logic [12:0] s);
    target_t m[13] = '{TGT_RAM, TGT_EXP_RAM, TGT_ROM, TGT_EXP_MEM, TGT_DMA1, TGT_PIC1,
      TGT_RTC, TGT_KBC, TGT_PAGE, TGT_PIC2, TGT_DMA2, TGT_FPU, TGT_EXP_IO};
    exp_tgt = TGT_NONE;
    for (int i = 0; i < 13; i++) if (s[12 - i]) exp_tgt = m[i];
  endfunction
  task automatic t_mem_map();
    logic [23:0] t[14] = '{24'h0, 24'h07ffff, 24'h080000, 24'h09ffff, 24'h0a0000, 24'h0c0000,
      24'h0dffff, 24'h0e0000, 24'h0fffff, 24'h100000, 24'hfdffff, 24'hfe0000, 24'hff1234,
      24'hffffff};
    foreach (t[j]) begin
      cpu.run(1'b1, t[j], 2 + j % 3);
      #1;
      `CHK("mem select", exp_sel(1'b1, t[j], 1'b0), sel_v)
      `CHK("mem tgt", exp_tgt(exp_sel(1'b1, t[j], 1'b0)), target_out)
    end
  endtask
  task automatic t_io_map();
    logic [23:0] t[24] = '{24'h0, 24'h01f, 24'h020, 24'h03f, 24'h040, 24'h05f, 24'h060,
      24'h06f, 24'h070, 24'h07f, 24'h080, 24'h09f, 24'h0a0, 24'h0bf, 24'h0c0, 24'h0df,
      24'h0e0, 24'h0f0, 24'h0f1, 24'h0f4, 24'h0f8, 24'h100, 24'h3ff, 24'habfc20};
    logic [1:0] f;
    foreach (t[j]) begin
      cpu.run(1'b0, t[j], 2);
      #1;
      f = {t[j] == 24'h0f0, t[j] == 24'h0f1};
      `CHK("io sel", exp_sel(1'b0, t[j], 1'b0), sel_v)
      `CHK("io tgt", exp_tgt(exp_sel(1'b0, t[j], 1'b0)), target_out)
      `CHK("fpu strobes", f, {fpu_clr_busy_out, fpu_reset_out})
    end
  endtask
  task automatic t_regs();
    av(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl reset", 32'h0, q)
    av(1'b1, 4'h2, 32'hf);
    av(1'b0, 4'h2, 32'h0);
    `CHK("unmapped", 32'h0, q)
    av(1'b1, CTRL_OFFSET, 32'h2);
    av(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("ctrl", 32'h2, q)
    cpu.run(1'b1, 24'h09ffff, 2);
    #1;
    `CHK("exp ram", exp_sel(1'b1, 24'h09ffff, 1'b1), sel_v)
    av(1'b1, CTRL_OFFSET, 32'h0);
  endtask
  task automatic t_straps(input logic [4:0] p);
    logic [7:0] e;
    {kbd_lock_in, display_type_switch_in, kbd_clk_in, kbd_data_in} <= p[3:0];
    repeat (8) @(posedge core_clk_in);
    e = {p[3], p[2], 1'b1, 5'h10};
    `CHK("kbc port", e, kbc_in_port_out)
    `CHK("test pins", p[1:0], {kbc_test0_out, kbc_test1_out})
    av(1'b0, KBC_IN_OFFSET, 32'h0);
    `CHK("kbc reg", {24'h0, e}, q)
    av(1'b0, KBC_TST_OFFSET, 32'h0);
    `CHK("test reg", {30'h0, p[0], p[1]}, q)
  endtask
  task automatic t_speed(input logic hi, input int e);
    int n;
    logic prev;
    av(1'b1, CTRL_OFFSET, {31'h0, hi});
    n = 0;
    prev = cpu_clk_out;
    repeat (280) begin
      @(posedge core_clk_in);
      n += (cpu_clk_out !== prev);
      prev = cpu_clk_out;
    end
    `CHK("led", hi, speed_led_hi_out)
    `CHK("cpu clock rate", 1'b1, n >= e - 1 && n <= e + 1)
  endtask
  task automatic t_speaker(input logic [3:0] c, input logic t, input logic e);
    av(1'b1, CTRL_OFFSET, {28'h0, c});
    timer2_out_in <= t;
    repeat (6) @(posedge core_clk_in);
    `CHK("speaker", e, speaker_out)
  endtask
  // A mid-run reset with the strap at high speed: selects stay low, then the strap is taken.
  task automatic t_reset();
    default_speed_strap_in <= 1'b0;
    srst_in <= 1'b1;
    cpu.run(1'b1, 24'h0, 4);
    #1;
    `CHK("sel in reset", 13'h0, sel_v)
    repeat (4) @(posedge core_clk_in);
    srst_in <= 1'b0;
    av(1'b0, CTRL_OFFSET, 32'h0);
    `CHK("strap speed", 32'h1, q)
    `CHK("strap bit", 1'b0, kbc_in_port_out[KBC_SPEED_BIT])
    `CHK("strap led", 1'b1, speed_led_hi_out)
  endtask
  initial begin
    {srst_in, default_speed_strap_in, kbd_lock_in} = 3'b111;
    {osc_clk_in, timer2_out_in, display_type_switch_in, kbd_clk_in, kbd_data_in} = 5'h0;
    {avs_read, avs_write, osc_en} = 3'b000;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    {error_cnt, n_compared, cyc} = 0;
    repeat (6) @(posedge core_clk_in);
    srst_in <= 1'b0;
    t_mem_map();
    t_io_map();
    t_regs();
    t_straps(5'h0a);
    t_straps(5'h05);
    osc_en <= 1'b1;
    t_speed(1'b0, 280 / (2 * LOW_HALF_CYC) * 2);
    t_speed(1'b1, 40);
    t_speaker(4'h4, 1'b1, 1'b0);
    t_speaker(4'hc, 1'b1, 1'b1);
    t_speaker(4'hc, 1'b0, 1'b0);
    t_reset();
    end_sim();
  end
endmodule
